/* File: shared/fan_mon_pkg.sv */
/*
 * fan_mon_pkg: register map, field layout, reset values and timing
 * constants of the fan monitor block.
 * assumes: a 125 MHz register clock and 32-bit APB data.
 */
package fan_mon_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_CONFIG     = 8'h00;
   localparam logic [7:0] OFS_SPEED      = 8'h04;
   localparam logic [7:0] OFS_COUNT_TIME = 8'h08;
   localparam logic [7:0] OFS_TACH       = 8'h0C;
   localparam logic [7:0] OFS_GPIO_DEF   = 8'h10;
   localparam logic [7:0] OFS_GPIO_STAT  = 8'h14;
   localparam logic [7:0] OFS_ALARM_EN   = 8'h18;
   localparam logic [7:0] OFS_ALARM_STAT = 8'h1C;

   // configuration fields
   localparam int CFG_PRESC_LSB = 0;
   localparam int CFG_MODE_LSB  = 4;

   // operating modes in configuration bits 5:4
   localparam logic [1:0] MODE_FULL_ON  = 2'h0;
   localparam logic [1:0] MODE_FULL_OFF = 2'h1;
   localparam logic [1:0] MODE_CLOSED   = 2'h2;
   localparam logic [1:0] MODE_OPEN     = 2'h3;

   // two-bit pin definition codes, pins 0 to 2
   localparam logic [1:0] PDEF_SPECIAL = 2'h1;
   localparam logic [1:0] PDEF_LOW     = 2'h2;
   localparam logic [1:0] PDEF_HIGH    = 2'h3;
   localparam logic [1:0] PDEF_CLK_IN  = 2'h0;

   // alarm bit positions, same in enable and status
   localparam int ALM_MIN_OUT  = 0;
   localparam int ALM_MAX_OUT  = 1;
   localparam int ALM_OVERFLOW = 2;
   localparam int ALM_PIN1_LOW = 3;
   localparam int ALM_PIN2_LOW = 4;

   // reset values
   localparam logic [7:0] RST_CONFIG     = 8'h00;
   localparam logic [7:0] RST_SPEED      = 8'hFF;
   localparam logic [1:0] RST_COUNT_TIME = 2'h2;
   localparam logic [7:0] RST_GPIO_DEF   = 8'hFF;
   localparam logic [4:0] RST_ALARM_EN   = 5'h00;

   // drive codes that raise the output alarms, and the saturating tach count that raises overflow
   localparam logic [7:0] DAC_FULL_VOLT = 8'h00;
   localparam logic [7:0] DAC_ZERO_VOLT = 8'hFF;
   localparam logic [7:0] TACH_MAX      = 8'hFF;

   // timing: register clock, oscillator and count-time unit
   localparam int PCLK_KHZ      = 125000;
   localparam int OSC_KHZ       = 254;
   localparam int OSC_HALF_CYC  = PCLK_KHZ / (2 * OSC_KHZ);
   localparam int COUNT_UNIT_MS = 250;
   localparam int COUNT_UNIT_CYC = COUNT_UNIT_MS * PCLK_KHZ;

   // open-drain drive of the five general-purpose pins
   typedef struct packed {
      logic [4:0] o;
      logic [4:0] oe;
   } gp_drive_t;

endpackage

/* File: hdl/fan_mon.sv */
/*
 * fan_mon: tachometer counter, general-purpose pins, clock sync pin and
 * alarm logic of a fan-speed controller, with an APB register slave.
 * assumes: pins and the external clock are asynchronous and are
 * synchronised here; the drive code comes from regulation logic on pclk.
 */
`timescale 1ns/1ps
module fan_mon #(
   parameter int UNIT_CYC = fan_mon_pkg::COUNT_UNIT_CYC,
   parameter int OSC_HALF = fan_mon_pkg::OSC_HALF_CYC
) (
   // clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // apb slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // fan side
   input  wire logic                   fan_pulse_in0,
   input  wire logic [7:0]             dac_code,
   output logic      [1:0]             fan_mode,
   output logic                        closed_loop,
   output logic      [7:0]             speed_target,
   output logic      [2:0]             loop_prescaler,
   output logic                        fan_clk_tick,
   // general-purpose pins
   input  wire logic [4:0]             gp_pin_in,
   output fan_mon_pkg::gp_drive_t      gp_drive,
   output logic                        alert_n
);
   import fan_mon_pkg::*;

   // refuse settings that the interval and oscillator counters cannot hold
   if (UNIT_CYC < 2 || OSC_HALF < 1 || OSC_HALF > 65536) begin : g_param_check
      $error("fan_mon: UNIT_CYC must be >= 2 and OSC_HALF in 1..65536");
   end

   logic [7:0]  config_reg;
   logic [7:0]  speed_reg;
   logic [1:0]  count_time_reg;
   logic [7:0]  tach_reg;
   logic [7:0]  gpio_def_reg;
   logic [4:0]  alarm_en_reg;
   logic [4:0]  alarm_stat_reg;
   logic [4:0]  alarm_stat_next;
   logic [4:0]  pin_meta_reg;
   logic [4:0]  pin_reg;
   logic [1:0]  tach_sync_reg;
   logic        tach_prev_reg;
   logic [7:0]  pulse_cnt_reg;
   logic [33:0] interval_cnt_reg;
   logic [33:0] interval_len;
   logic [15:0] osc_cnt_reg;
   logic        osc_clk_reg;
   logic        clk_prev_reg;
   logic        full_on;
   logic        wr_en;
   logic        rd_en;
   logic        addr_ok;
   logic [4:0]  alarm_cond;
   logic        tach_edge;
   logic        interval_end;
   logic        sel_clk;

   // apb handshake: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && penable && !pwrite;

   // address decode
   always_comb begin
      case (paddr)
         OFS_CONFIG, OFS_SPEED, OFS_COUNT_TIME, OFS_TACH,
         OFS_GPIO_DEF, OFS_GPIO_STAT, OFS_ALARM_EN, OFS_ALARM_STAT: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !addr_ok;

   // read data mux, unmapped reads return zero
   always_comb begin
      case (paddr)
         OFS_CONFIG:     prdata = {24'h000000, config_reg};
         OFS_SPEED:      prdata = {24'h000000, speed_reg};
         OFS_COUNT_TIME: prdata = {30'h00000000, count_time_reg};
         OFS_TACH:       prdata = {24'h000000, tach_reg};
         OFS_GPIO_DEF:   prdata = {24'h000000, gpio_def_reg};
         OFS_GPIO_STAT:  prdata = {27'h0000000, pin_reg};
         OFS_ALARM_EN:   prdata = {27'h0000000, alarm_en_reg};
         OFS_ALARM_STAT: prdata = {27'h0000000, alarm_stat_reg};
         default:        prdata = 32'h00000000;
      endcase
   end

   // software-written registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_reg     <= RST_CONFIG;
         speed_reg      <= RST_SPEED;
         count_time_reg <= RST_COUNT_TIME;
         gpio_def_reg   <= RST_GPIO_DEF;
         alarm_en_reg   <= RST_ALARM_EN;
      end else if (wr_en) begin
         case (paddr)
            OFS_CONFIG:     config_reg     <= pwdata[7:0];
            OFS_SPEED:      speed_reg      <= pwdata[7:0];
            OFS_COUNT_TIME: count_time_reg <= pwdata[1:0];
            OFS_GPIO_DEF:   gpio_def_reg   <= pwdata[7:0];
            OFS_ALARM_EN:   alarm_en_reg   <= pwdata[4:0];
            default: ;
         endcase
      end
   end

   // two-flop synchronisers for pins and the fan pulse input
   // pins reset high so no pin-low alarm follows reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_reg  <= 5'h1F;
         pin_reg       <= 5'h1F;
         tach_sync_reg <= 2'h0;
         tach_prev_reg <= 1'b0;
      end else begin
         pin_meta_reg  <= gp_pin_in;
         pin_reg       <= pin_meta_reg;
         tach_sync_reg <= {tach_sync_reg[0], fan_pulse_in0};
         tach_prev_reg <= tach_sync_reg[1];
      end
   end
   // prev resets to the idle low level of the pulse input, so no false edge
   assign tach_edge = tach_sync_reg[1] && !tach_prev_reg;

   // interval length doubles per count-time step
   assign interval_len = 34'(UNIT_CYC) << count_time_reg;
   assign interval_end = (interval_cnt_reg >= interval_len - 34'h000000001);

   // raw pulse counter, saturating, prescaler not involved
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interval_cnt_reg <= 34'h000000000;
         pulse_cnt_reg    <= 8'h00;
         tach_reg         <= 8'h00;
      end else if (interval_end) begin
         interval_cnt_reg <= 34'h000000000;
         tach_reg         <= pulse_cnt_reg;
         pulse_cnt_reg    <= 8'h00;
      end else begin
         interval_cnt_reg <= interval_cnt_reg + 34'h000000001;
         if (tach_edge && pulse_cnt_reg != TACH_MAX) begin
            pulse_cnt_reg <= pulse_cnt_reg + 8'h01;
         end
      end
   end

   // internal oscillator derived from pclk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_cnt_reg <= 16'h0000;
         osc_clk_reg <= 1'b0;
      end else if (osc_cnt_reg >= 16'(OSC_HALF - 1)) begin
         osc_cnt_reg <= 16'h0000;
         osc_clk_reg <= !osc_clk_reg;
      end else begin
         osc_cnt_reg <= osc_cnt_reg + 16'h0001;
      end
   end

   // fan clock source: external clock on pin 2 or the oscillator
   // a source change may give one stray tick; let the clock settle after it
   assign sel_clk = (gpio_def_reg[5:4] == PDEF_CLK_IN) ? pin_reg[2] : osc_clk_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_prev_reg <= 1'b0;
         fan_clk_tick <= 1'b0;
      end else begin
         clk_prev_reg <= sel_clk;
         fan_clk_tick <= sel_clk && !clk_prev_reg;
      end
   end

   // full-on override and effective mode
   assign full_on = (gpio_def_reg[3:2] == PDEF_SPECIAL) && !pin_reg[1];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fan_mode       <= MODE_FULL_ON;
         closed_loop    <= 1'b0;
         speed_target   <= RST_SPEED;
         loop_prescaler <= 3'h0;
      end else begin
         fan_mode       <= full_on ? MODE_FULL_ON : config_reg[CFG_MODE_LSB +: 2];
         closed_loop    <= !full_on && config_reg[CFG_MODE_LSB +: 2] == MODE_CLOSED;
         speed_target   <= speed_reg;
         loop_prescaler <= config_reg[CFG_PRESC_LSB +: 3];
      end
   end

   // live alarm conditions, at their enable bit positions
   always_comb begin
      alarm_cond               = 5'h00;
      alarm_cond[ALM_MIN_OUT]  = (dac_code == DAC_FULL_VOLT);
      alarm_cond[ALM_MAX_OUT]  = (dac_code == DAC_ZERO_VOLT);
      alarm_cond[ALM_OVERFLOW] = (tach_reg == TACH_MAX);
      alarm_cond[ALM_PIN1_LOW] = !pin_reg[1];
      alarm_cond[ALM_PIN2_LOW] = !pin_reg[2];
   end

   // sticky status; a read reloads it from the live causes, so set wins
   always_comb begin
      if (rd_en && paddr == OFS_ALARM_STAT) begin
         alarm_stat_next = alarm_cond & alarm_en_reg;
      end else begin
         alarm_stat_next = alarm_stat_reg | (alarm_cond & alarm_en_reg);
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_stat_reg <= 5'h00;
      end else begin
         alarm_stat_reg <= alarm_stat_next;
      end
   end

   // alert from enabled status bits only, so disabling releases it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alert_n <= 1'b1;
      end else begin
         alert_n <= !(|(alarm_stat_next & alarm_en_reg));
      end
   end

   // open-drain pin drive: oe high pulls the pin low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gp_drive <= '{o: 5'h00, oe: 5'h00};
      end else begin
         gp_drive.o     <= 5'h00;
         gp_drive.oe[0] <= (gpio_def_reg[1:0] == PDEF_LOW) ||
                           (gpio_def_reg[1:0] == PDEF_SPECIAL &&
                            (|(alarm_stat_next & alarm_en_reg)));
         gp_drive.oe[1] <= (gpio_def_reg[3:2] == PDEF_LOW);
         gp_drive.oe[2] <= (gpio_def_reg[5:4] == PDEF_LOW) ||
                           (gpio_def_reg[5:4] == PDEF_SPECIAL && !osc_clk_reg);
         gp_drive.oe[3] <= !gpio_def_reg[6];
         gp_drive.oe[4] <= !gpio_def_reg[7];
      end
   end

   // checks
   AST_PIN0_LOW: assert property (@(posedge pclk) disable iff (!presetn)
      gpio_def_reg[1:0] == PDEF_LOW |=> gp_drive.oe[0])
      else $error("pin 0 not driven low");
   AST_PIN3_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
      gpio_def_reg[6] |=> !gp_drive.oe[3])
      else $error("pin 3 not released");
   AST_ALERT_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
      !alert_n && !rd_en && $stable(alarm_en_reg) |=> !alert_n)
      else $error("alert dropped without a status read");
   AST_ALERT_FIRE: assert property (@(posedge pclk) disable iff (!presetn)
      |(alarm_cond & alarm_en_reg) |=> !alert_n)
      else $error("enabled alarm did not assert alert");
   AST_DISABLE: assert property (@(posedge pclk) disable iff (!presetn)
      alarm_en_reg == 5'h00 |=> alert_n)
      else $error("alert active with all alarms disabled");
   AST_READ_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && paddr == OFS_ALARM_STAT && |(alarm_cond & alarm_en_reg) |=> !alert_n)
      else $error("read released alert while cause persists");
   AST_SATURATE: assert property (@(posedge pclk) disable iff (!presetn)
      pulse_cnt_reg == TACH_MAX && !interval_end |=> pulse_cnt_reg == TACH_MAX)
      else $error("pulse counter wrapped");
   AST_FULL_ON: assert property (@(posedge pclk) disable iff (!presetn)
      full_on |=> fan_mode == MODE_FULL_ON && !closed_loop)
      else $error("full-on override ignored");
   AST_TACH_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
      interval_end |=> tach_reg == $past(pulse_cnt_reg))
      else $error("tach count not captured at interval end");
   AST_DAC_MIN: assert property (@(posedge pclk) disable iff (!presetn)
      dac_code == DAC_FULL_VOLT && alarm_en_reg[ALM_MIN_OUT] |=> alarm_stat_reg[ALM_MIN_OUT])
      else $error("minimum output alarm missed");

   // alarm sources, pin modes and loop mode
   AST_DAC_MAX: assert property (@(posedge pclk) disable iff (!presetn)
      dac_code == DAC_ZERO_VOLT && alarm_en_reg[ALM_MAX_OUT] |=> alarm_stat_reg[ALM_MAX_OUT])
      else $error("maximum output alarm missed");
   AST_OVERFLOW: assert property (@(posedge pclk) disable iff (!presetn)
      tach_reg == TACH_MAX && alarm_en_reg[ALM_OVERFLOW] |=> alarm_stat_reg[ALM_OVERFLOW])
      else $error("overflow alarm missed");
   AST_PIN1_ALARM: assert property (@(posedge pclk) disable iff (!presetn)
      !pin_reg[1] && alarm_en_reg[ALM_PIN1_LOW] |=> alarm_stat_reg[ALM_PIN1_LOW])
      else $error("pin 1 low alarm missed");
   AST_PIN2_ALARM: assert property (@(posedge pclk) disable iff (!presetn)
      !pin_reg[2] && alarm_en_reg[ALM_PIN2_LOW] |=> alarm_stat_reg[ALM_PIN2_LOW])
      else $error("pin 2 low alarm missed");
   AST_ALERT_PIN: assert property (@(posedge pclk) disable iff (!presetn)
      gpio_def_reg[1:0] == PDEF_SPECIAL |=> gp_drive.oe[0] == !alert_n)
      else $error("pin 0 does not follow the alert");
   AST_CLOSED_LOOP: assert property (@(posedge pclk) disable iff (!presetn)
      config_reg[CFG_MODE_LSB +: 2] == MODE_CLOSED && !full_on |=> closed_loop)
      else $error("closed loop not selected");
   AST_CLK_OUT: assert property (@(posedge pclk) disable iff (!presetn)
      gpio_def_reg[5:4] == PDEF_SPECIAL |=> gp_drive.oe[2] == !$past(osc_clk_reg))
      else $error("pin 2 does not carry the oscillator");
   AST_PIN4_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
      gpio_def_reg[7] |=> !gp_drive.oe[4])
      else $error("pin 4 not released");

   COV_ALERT: cover property (@(posedge pclk) disable iff (!presetn) $fell(alert_n));
   COV_CLEAR: cover property (@(posedge pclk) disable iff (!presetn) $rose(alert_n));
   COV_OVF: cover property (@(posedge pclk) disable iff (!presetn) tach_reg == TACH_MAX);
   COV_FULLON: cover property (@(posedge pclk) disable iff (!presetn) full_on);
   COV_CLK_IN: cover property (@(posedge pclk) disable iff (!presetn)
      fan_clk_tick && gpio_def_reg[5:4] == PDEF_CLK_IN);

endmodule

/* File: dv/fan_pins_model.sv */
/*
 * fan_pins_model: board side of the five general-purpose pins.
 * assumes: open-drain drive from fan_mon, a weak pullup on every pin,
 * and a second controller that can act as clock source on pin 2.
 */
`timescale 1ns/1ps
module fan_pins_model (
   // drive from the block
   input  wire fan_mon_pkg::gp_drive_t gp_drive,
   // board controls
   input  wire logic [4:0]             ext_low,
   input  wire logic                   clk_en,
   // levels seen by the block
   output logic      [4:0]             gp_pin_in
);
   import fan_mon_pkg::*;
   logic ext_clk = 1'b1;

   // foreign clock source on the shared pin, stands high when idle
   always #40 ext_clk = clk_en ? ~ext_clk : 1'b1;

   // wired-and of pullup, block pull-down and outside pull-down
   assign gp_pin_in = ~(gp_drive.oe | ext_low) & {2'b11, ext_clk, 2'b11};
endmodule

/* File: dv/fan_tach_gpio_alarm_logic_test.sv */
/*
 * fan_tach_gpio_alarm_logic_test: self-checking bench of fan_mon.
 * assumes: short count unit and oscillator set by parameters, pins
 * modelled by fan_pins_model, APB master with no fixed latency.
 */
`timescale 1ns/1ps
module fan_tach_gpio_alarm_logic_test;
   import fan_mon_pkg::*;
   localparam int UNIT = 200;
   localparam int PER  = 6;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, prev;
   logic [7:0]  paddr = '0, dac_code = 8'h80, def, speed_target;
   logic [31:0] pwdata = '0, prdata, q;
   logic        pready, pslverr, fan_pulse_in0 = 0, pulse_on = 0, closed_loop, fan_clk_tick;
   logic        alert_n, clk_en = 0;
   logic [1:0]  fan_mode;
   logic [2:0]  loop_prescaler;
   logic [4:0]  gp_pin_in, ext_low = '0;
   logic [4:0]  ens [4] = '{5'h03, 5'h03, 5'h08, 5'h10};
   gp_drive_t   gp_drive;
   int          num_errors = 0, check_count = 0, n, pc = 0, r;

   fan_mon #(.UNIT_CYC(UNIT), .OSC_HALF(4)) fan_mon_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .fan_pulse_in0(fan_pulse_in0),
      .dac_code(dac_code), .fan_mode(fan_mode), .closed_loop(closed_loop),
      .speed_target(speed_target), .loop_prescaler(loop_prescaler),
      .fan_clk_tick(fan_clk_tick), .gp_pin_in(gp_pin_in), .gp_drive(gp_drive),
      .alert_n(alert_n));
   fan_pins_model fan_pins_model_i (.gp_drive(gp_drive), .ext_low(ext_low),
      .clk_en(clk_en), .gp_pin_in(gp_pin_in));

   // clock
   initial forever #4 pclk = ~pclk;

   // tach pulses, period PER cycles while enabled
   always @(posedge pclk) begin
      pc <= (pc == PER - 1) ? 0 : pc + 1;
      fan_pulse_in0 <= pulse_on && (pc < PER / 2);
   end

   task cyc(input int c);
      repeat (c) @(posedge pclk);
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // tolerance of one unit for free-running phase
   task near(input logic [31:0] seen, input int exp);
      check({31'h0, (seen + 1 >= exp) && (seen <= exp + 1)}, 32'h1);
   endtask

   // one apb transfer, read data and error taken at the pready edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // count rising edges of the pin 2 drive or the fan clock tick
   task count_rise(input logic use_tick, input int c);
      n = 0;
      prev = 1'b0;
      repeat (c) begin
         @(posedge pclk);
         if ((use_tick ? fan_clk_tick : gp_drive.oe[2]) && !prev) n++;
         prev = use_tick ? 1'b0 : gp_drive.oe[2];
      end
   endtask

   task report_and_stop;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // watchdog
   initial begin
      cyc(40000);
      num_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      report_and_stop;
   end

   initial begin
      void'($urandom(16583));
      cyc(10);
      presetn <= 1'b1;
      cyc(3);
      apb(1'b0, OFS_GPIO_DEF, 0);
      check(q, 32'hFF);
      check(32'(gp_drive), 32'h0);
      apb(1'b0, 8'h40, 0);
      check({q[30:0], err}, 32'h1);
      $display("test reset done");
      // each pin pulled low alone, then all released
      for (int p = 0; p < 5; p++) begin
         def = 8'hFF;
         if (p < 3) def[2*p +: 2] = PDEF_LOW;
         else def[p + 3] = 1'b0;
         apb(1'b1, OFS_GPIO_DEF, 32'(def));
         cyc(4);
         check(32'(gp_drive.oe), 32'h1 << p);
         apb(1'b0, OFS_GPIO_STAT, 0);
         check(q, 32'h1F ^ (32'h1 << p));
      end
      apb(1'b1, OFS_GPIO_DEF, 32'hFF);
      ext_low <= 5'h08;
      cyc(4);
      check(32'(gp_drive), 32'h0);
      apb(1'b0, OFS_GPIO_STAT, 0);
      check(q, 32'h17);
      ext_low <= 5'h00;
      $display("test pins done");
      // tach count per interval with a random prescaler
      pulse_on <= 1'b1;
      for (int ct = 0; ct < 4; ct++) begin
         r = int'($urandom_range(7, 0));
         apb(1'b1, OFS_CONFIG, 32'(r));
         apb(1'b1, OFS_COUNT_TIME, 32'(ct));
         cyc(UNIT * 8 + ((2 * UNIT) << ct));
         check(32'(loop_prescaler), 32'(r));
         apb(1'b0, OFS_TACH, 0);
         n = (UNIT << ct) / PER;
         if (n > 255) n = 255;
         near(q, 32'(n));
      end
      $display("test tach done");
      // overflow alarm, latched, released by a status read once the count drops
      apb(1'b1, OFS_GPIO_DEF, 32'hFD);
      apb(1'b1, OFS_ALARM_EN, 32'h04);
      cyc(3);
      check(32'({alert_n, gp_drive.oe}), 32'h01);
      apb(1'b0, OFS_ALARM_STAT, 0);
      cyc(2);
      check({q[30:0], alert_n}, {31'h4, 1'b0});
      pulse_on <= 1'b0;
      cyc(UNIT * 20);
      check(32'(alert_n), 32'h0);
      apb(1'b0, OFS_ALARM_STAT, 0);
      cyc(2);
      check({q[25:0], alert_n, gp_drive.oe}, {26'h4, 1'b1, 5'h00});
      // output and pin-low alarms
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, OFS_ALARM_EN, 32'(ens[k]));
         if (k < 2) dac_code <= k ? DAC_ZERO_VOLT : DAC_FULL_VOLT;
         else ext_low <= (k == 2) ? 5'h02 : 5'h04;
         cyc(5);
         check(32'({alert_n, gp_drive.oe}), 32'h01);
         dac_code <= 8'($urandom_range(254, 1));
         ext_low <= 5'h00;
         cyc(5);
         check(32'(alert_n), 32'h0);
         apb(1'b0, OFS_ALARM_STAT, 0);
         cyc(2);
         check({q[30:0], alert_n}, {31'h1 << (k < 2 ? k : k + 1), 1'b1});
      end
      apb(1'b1, OFS_ALARM_EN, 32'h01);
      dac_code <= DAC_FULL_VOLT;
      cyc(4);
      check(32'(alert_n), 32'h0);
      apb(1'b1, OFS_ALARM_EN, 32'h00);
      cyc(2);
      check(32'(alert_n), 32'h1);
      $display("test alarms done");
      // second reset in mid-run brings back the power-up state
      presetn <= 1'b0;
      cyc(4);
      check(32'({alert_n, fan_mode, speed_target}), 32'h4FF);
      presetn <= 1'b1;
      cyc(3);
      apb(1'b0, OFS_GPIO_DEF, 0);
      check(q, 32'hFF);
      check(32'(gp_drive), 32'h0);
      apb(1'b0, OFS_ALARM_EN, 0);
      check(q, 32'h0);
      $display("test second reset done");
      // speed target and closed loop with full-on override
      r = int'($urandom_range(255, 0));
      apb(1'b1, OFS_SPEED, 32'(r));
      apb(1'b0, OFS_SPEED, 0);
      check(q, 32'(r));
      check(32'(speed_target), 32'(r));
      apb(1'b1, OFS_CONFIG, {26'h0, MODE_CLOSED, 4'h1});
      apb(1'b1, OFS_GPIO_DEF, 32'hFF);
      ext_low <= 5'h02;
      cyc(5);
      check(32'({fan_mode, closed_loop}), {29'h0, MODE_CLOSED, 1'b1});
      apb(1'b1, OFS_GPIO_DEF, 32'hF7);
      cyc(5);
      check(32'({fan_mode, closed_loop}), {29'h0, MODE_FULL_ON, 1'b0});
      ext_low <= 5'h00;
      cyc(5);
      check(32'({fan_mode, closed_loop}), {29'h0, MODE_CLOSED, 1'b1});
      $display("test override done");
      // clock out on pin 2, then external clock in
      apb(1'b1, OFS_GPIO_DEF, 32'hDF);
      count_rise(1'b0, 80);
      near(32'(n), 10);
      apb(1'b1, OFS_GPIO_DEF, 32'hCF);
      clk_en <= 1'b1;
      cyc(10);
      count_rise(1'b1, 200);
      near(32'(n), 20);
      clk_en <= 1'b0;
      $display("test clock done");
      report_and_stop;
   end
endmodule
